/* File: common/rpw_consts.svh */
/*
  constants for the rtc pin and wake control block.
  assumes it is included by bare name from package and design files.
*/
`ifndef RPW_CONSTS_SVH
`define RPW_CONSTS_SVH
`define RPW_ADDR_W        16
`define RPW_RTC_BASE      16'h1900
`define RPW_RTC_LAST      16'h197f
`define RPW_PMGT_ADDR     16'h1928
`define RPW_PMGT_CLKOUT_BIT 0
`define RPW_PMGT_WAKEOUT_BIT 1
`define RPW_PMGT_RESET    16'h0000
`define RPW_WAKE_ACTIVE   1'b0
`define RPW_WAKE_BLANK    3'd5
`endif

/* File: common/rpw_pkg.sv */
/*
  types for the rtc pin and wake control block.
  assumes rpw_consts.svh is on the include path.
*/
`include "rpw_consts.svh"
package rpw_pkg;
  typedef struct packed {
    logic req;
    logic wr;
    logic [`RPW_ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } rpw_io_req_s;
  typedef struct packed {
    logic o;
    logic oe;
  } rpw_pin_out_s;
  typedef enum logic [1:0] {
    WK_INPUT,
    WK_OUT_IDLE,
    WK_OUT_PULL
  } rpw_wake_e;
endpackage : rpw_pkg

/* File: hw/rpw_sync3.sv */
/*
  three-flop synchroniser with agreement of the last two stages.
  assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module rpw_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic       out_reg;
  logic       out_next;

  always_comb begin
    sh_next  = {sh_reg[1:0], din};
    // first stage only feeds the second
    out_next = (sh_reg[2] == sh_reg[1]) ? sh_reg[2] : out_reg;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sh_reg  <= {3{RST_VAL}};
      out_reg <= RST_VAL;
    end else begin
      sh_reg  <= sh_next;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;
endmodule : rpw_sync3

/* File: hw/rpw_top.sv */
/*
  rtc pin and wake control: access gating of the rtc window, clock output pin
  enable, and the two-way wake pin.
  assumes osc_running, the rtc clock level, the wake pin level and the alarm come
  from other domains or pins; the io request comes from core_clk logic.
*/
`timescale 1ns/1ps
`include "rpw_consts.svh"
module rpw_top
  import rpw_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire rpw_io_req_s  io_req,
  output logic              io_ack,
  output logic              io_blocked,
  output logic [15:0]       io_rdata,
  output logic              rtc_sel,
  input  wire logic         osc_running,
  input  wire logic         rtc_clk_level,
  input  wire logic         alarm_in,
  output rpw_pin_out_s      rtc_clock_output_pin,
  input  wire logic         wake_pin_i,
  output logic              wake_pin_o,
  output logic              wake_pin_oe,
  output logic              core_wake
);

  ////////////////////////////////////////////////////////////////////////////
  logic osc_ok;
  logic rtc_clk_s;
  logic alarm_s;
  logic wake_s;

  rpw_sync3 #(.RST_VAL(1'b0)) u_osc (.core_clk(core_clk), .sys_rst(sys_rst), .din(osc_running), .dout(osc_ok));
  rpw_sync3 #(.RST_VAL(1'b0)) u_clk (.core_clk(core_clk), .sys_rst(sys_rst), .din(rtc_clk_level), .dout(rtc_clk_s));
  rpw_sync3 #(.RST_VAL(1'b0)) u_alm (.core_clk(core_clk), .sys_rst(sys_rst), .din(alarm_in), .dout(alarm_s));
  // idle pin level is high (pulled up), so reset to high to avoid a false wake
  rpw_sync3 #(.RST_VAL(1'b1)) u_wak (.core_clk(core_clk), .sys_rst(sys_rst), .din(wake_pin_i), .dout(wake_s));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic in_rtc(input logic [`RPW_ADDR_W-1:0] a);
    in_rtc = (a >= `RPW_RTC_BASE) && (a <= `RPW_RTC_LAST);
  endfunction : in_rtc

  logic [15:0] rtc_power_management_reg;
  logic [15:0] rtc_power_management_next;
  logic        ack_reg;
  logic        ack_next;
  logic        blk_reg;
  logic        blk_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        hit;
  logic        pm_hit;

  always_comb begin
    hit        = io_req.req && in_rtc(io_req.addr);
    pm_hit     = hit && osc_ok && (io_req.addr == `RPW_PMGT_ADDR);
    rtc_power_management_next = rtc_power_management_reg;
    ack_next   = hit && osc_ok;
    blk_next   = hit && !osc_ok;
    rdata_next = 16'h0000;
    if (pm_hit && io_req.wr) begin
      rtc_power_management_next = io_req.wdata;
    end else if (pm_hit) begin
      rdata_next = rtc_power_management_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rtc_power_management_reg <= `RPW_PMGT_RESET;
      ack_reg   <= 1'b0;
      blk_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      rtc_power_management_reg <= rtc_power_management_next;
      ack_reg   <= ack_next;
      blk_reg   <= blk_next;
      rdata_reg <= rdata_next;
    end
  end

  assign io_ack     = ack_reg;
  assign io_blocked = blk_reg;
  assign io_rdata   = rdata_reg;
  // rtc core sees a select only while its oscillator runs
  assign rtc_sel    = hit && osc_ok;

  ////////////////////////////////////////////////////////////////////////////
  logic       rtc_clock_output_enable;
  logic       wake_out_mode;
  always_comb begin
    rtc_clock_output_enable = rtc_power_management_reg[`RPW_PMGT_CLKOUT_BIT];
    wake_out_mode           = rtc_power_management_reg[`RPW_PMGT_WAKEOUT_BIT];
  end
  // clock is resampled on core_clk: jitter of one core period is the trade-off
  // a disabled pin keeps o quiet so nothing toggles behind the tri-state
  always_comb begin
    rtc_clock_output_pin.o  = rtc_clock_output_enable ? rtc_clk_s : 1'b0;
    rtc_clock_output_pin.oe = rtc_clock_output_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  rpw_wake_e wk_reg;
  rpw_wake_e wk_next;
  logic      cw_reg;
  logic      cw_next;
  logic [2:0] blank_reg;
  logic [2:0] blank_next;

  always_comb begin
    wk_next = wk_reg;
    case (wk_reg)
      WK_INPUT: begin
        if (wake_out_mode) wk_next = alarm_s ? WK_OUT_PULL : WK_OUT_IDLE;
      end
      WK_OUT_IDLE: begin
        if (!wake_out_mode) wk_next = WK_INPUT;
        else if (alarm_s) wk_next = WK_OUT_PULL;
      end
      WK_OUT_PULL: begin
        if (!wake_out_mode) wk_next = WK_INPUT;
        else if (!alarm_s) wk_next = WK_OUT_IDLE;
      end
      default: wk_next = WK_INPUT;
    endcase
    // own pull would read back as a wake, so only input mode wakes the core;
    // the synchroniser still holds the pulled level for a few edges after
    // leaving output mode, so wakes are blanked until it has flushed
    if (wk_reg != WK_INPUT) begin
      blank_next = `RPW_WAKE_BLANK;
    end else if (blank_reg != 3'd0) begin
      blank_next = blank_reg - 3'd1;
    end else begin
      blank_next = 3'd0;
    end
    cw_next = (wk_reg == WK_INPUT) && (blank_reg == 3'd0) && (wake_s == `RPW_WAKE_ACTIVE);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wk_reg <= WK_INPUT;
      cw_reg <= 1'b0;
      blank_reg <= 3'd0;
    end else begin
      wk_reg <= wk_next;
      cw_reg <= cw_next;
      blank_reg <= blank_next;
    end
  end

  assign wake_pin_o  = 1'b0;
  assign wake_pin_oe = (wk_reg == WK_OUT_PULL);
  assign core_wake   = cw_reg;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_alarm_on;
    wake_out_mode && alarm_s;
  endsequence

  sequence s_rtc_take;
    io_req.req && in_rtc(io_req.addr) && osc_ok;
  endsequence

  sequence s_pm_read;
    io_req.req && !io_req.wr && (io_req.addr == `RPW_PMGT_ADDR) && osc_ok;
  endsequence

  a_gate_blocks: assert property (@(posedge core_clk) disable iff (sys_rst)
    (io_req.req && in_rtc(io_req.addr) && !osc_ok) |=> (io_blocked && !io_ack))
    else $error("rtc access not blocked with oscillator off");
  a_no_sel_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    !osc_ok |-> !rtc_sel)
    else $error("rtc select while oscillator off");
  a_clkout_tri: assert property (@(posedge core_clk) disable iff (sys_rst)
    !rtc_power_management_reg[`RPW_PMGT_CLKOUT_BIT] |-> !rtc_clock_output_pin.oe)
    else $error("clock output driven while disabled");
  a_clkout_rst: assert property (@(posedge core_clk)
    $fell(sys_rst) |-> !rtc_clock_output_pin.oe)
    else $error("clock output enabled after reset");
  a_wake_core: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wk_reg == WK_INPUT && blank_reg == 3'd0 && !wake_s) |=> core_wake)
    else $error("input wake did not wake core");
  a_wake_dflt: assert property (@(posedge core_clk)
    $fell(sys_rst) |-> (wk_reg == WK_INPUT && !wake_pin_oe))
    else $error("wake pin not input after reset");
  a_alarm_pull: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_alarm_on ##1 s_alarm_on |-> (wake_pin_oe && !wake_pin_o))
    else $error("alarm did not pull wake pin");
  a_wake_release: assert property (@(posedge core_clk) disable iff (sys_rst)
    wake_pin_oe |-> $past(alarm_s) && $past(wake_out_mode))
    else $error("wake pin pulled without alarm");
  a_gate_acks: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_rtc_take |=> (io_ack && !io_blocked))
    else $error("rtc access not acknowledged with oscillator on");
  a_gate_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(io_req.req && in_rtc(io_req.addr)) |=> (!io_ack && !io_blocked))
    else $error("answer without an rtc window request");
  a_sel_window: assert property (@(posedge core_clk) disable iff (sys_rst)
    rtc_sel |-> (io_req.req && in_rtc(io_req.addr)))
    else $error("rtc select outside the window");
  a_write_drop: assert property (@(posedge core_clk) disable iff (sys_rst)
    !osc_ok |=> $stable(rtc_power_management_reg))
    else $error("control register changed with oscillator off");
  a_read_data: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_pm_read |=> (io_ack && io_rdata == $past(rtc_power_management_reg)))
    else $error("control register read back wrong");
  a_clkout_on: assert property (@(posedge core_clk) disable iff (sys_rst)
    rtc_clock_output_enable |-> (rtc_clock_output_pin.oe && rtc_clock_output_pin.o == rtc_clk_s))
    else $error("clock output not driven while enabled");
  a_wake_in_tri: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wk_reg == WK_INPUT) |-> !wake_pin_oe)
    else $error("wake pin driven while an input");
  a_wake_od: assert property (@(posedge core_clk) disable iff (sys_rst)
    wake_pin_oe |-> !wake_pin_o)
    else $error("wake pin driven high");
  a_wake_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wake_out_mode && !alarm_s) |=> !wake_pin_oe)
    else $error("wake pin held low without alarm");
  a_wake_mode_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    !wake_out_mode |=> !wake_pin_oe)
    else $error("wake pin pulled in input mode");
  a_wake_blank: assert property (@(posedge core_clk) disable iff (sys_rst)
    (blank_reg != 3'd0) |=> !core_wake)
    else $error("core woken while wake input was blanked");
  a_own_pull: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wk_reg != WK_INPUT) |=> !core_wake)
    else $error("own wake pull woke the core");
endmodule : rpw_top

/* File: dv/rpw_far_model.sv */
/*
  far side of the wake pin: pull-up plus an external device that may pull low.
  assumes the block drives wake_pin_o and wake_pin_oe as an open-drain pair.
*/
`timescale 1ns/1ps
module rpw_far_model (
  input  wire logic wake_pin_o,
  input  wire logic wake_pin_oe,
  input  wire logic ext_pull_n,
  output logic      wake_wire
);
  // wired-and with a pull-up, so a released line reads high and never holds its old value
  assign wake_wire = ((wake_pin_oe && !wake_pin_o) || !ext_pull_n) ? 1'b0 : 1'b1;
endmodule : rpw_far_model

/* File: dv/rpw_top_tb.sv */
/*
  self-checking bench for rpw_top with an integer model of the access window.
  assumes the assertions live in the design files.
*/
`timescale 1ns/1ps
module rpw_top_tb;
  import rpw_pkg::*;
  logic core_clk = 0, sys_rst = 1, osc_running = 0, rtc_clk_level = 0, alarm_in = 0, ext_pull_n = 1;
  logic io_ack, io_blocked, rtc_sel, wake_pin_o, wake_pin_oe, core_wake, wake_wire, clk_prev;
  logic [15:0] edge_addr [4] = '{16'h18ff, 16'h1900, 16'h197f, 16'h1980};
  logic [15:0] io_rdata;
  logic [31:0] lfsr = 32'h1ad503fb;
  rpw_io_req_s io_req = '0;
  rpw_pin_out_s clk_pin;
  int fails = 0, num_checks = 0, pmgt = 0, i, rtc_div = 0, flips;
  always #5 core_clk = ~core_clk;
  // slow rtc clock, so the synchroniser sees each level on several samples
  always @(posedge core_clk) begin
    rtc_div <= (rtc_div == 2) ? 0 : rtc_div + 1;
    if (rtc_div == 2) rtc_clk_level <= #1 ~rtc_clk_level;
  end
  rpw_top rpw_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .io_req(io_req), .io_ack(io_ack),
    .io_blocked(io_blocked), .io_rdata(io_rdata), .rtc_sel(rtc_sel), .osc_running(osc_running),
    .rtc_clk_level(rtc_clk_level), .alarm_in(alarm_in), .rtc_clock_output_pin(clk_pin),
    .wake_pin_i(wake_wire), .wake_pin_o(wake_pin_o), .wake_pin_oe(wake_pin_oe), .core_wake(core_wake));
  rpw_far_model rpw_far_model_inst (.wake_pin_o(wake_pin_o), .wake_pin_oe(wake_pin_oe),
    .ext_pull_n(ext_pull_n), .wake_wire(wake_wire));
  ////////////////////////////////////////////////////////////////////////////////
  function logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task print_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  // one-cycle request, answer sampled one edge later
  task acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
    logic win;
    win = (a >= 16'h1900) && (a <= 16'h197f);
    io_req = '{1'b1, wr, a, d};
    #1;
    chk(rtc_sel, win && osc_running);
    cyc(1);
    io_req.req = 1'b0;
    chk({io_ack, io_blocked}, {win && osc_running, win && !osc_running});
    if (io_ack === 1'b1 && !wr) chk(io_rdata, (a == 16'h1928) ? pmgt[15:0] : 16'h0000);
    if (win && osc_running && wr && a == 16'h1928) pmgt = d;
    cyc(1);
  endtask : acc
  // bounded wait on core_wake (sel 0) or wake_pin_oe (sel 1)
  task wt(input logic sel, input logic v);
    for (i = 0; i < 8 && (sel ? wake_pin_oe : core_wake) !== v; i++) cyc(1);
    chk(sel ? wake_pin_oe : core_wake, v);
    if (i == 8) print_verdict;
  endtask : wt
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(10);
    sys_rst = 0;
    cyc(1);
    chk(clk_pin.oe, 1'b0);
    chk({wake_pin_oe, core_wake}, 2'b00);
    $display("test reset done");
    foreach (edge_addr[k]) acc(1'b0, edge_addr[k], 16'h0000);
    acc(1'b1, 16'h1928, 16'h0001);
    osc_running = 1;
    cyc(6);
    acc(1'b0, 16'h1928, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      lfsr = nxt(lfsr);
      acc(1'b0, 16'h18f8 + {8'h00, lfsr[7:0]}, lfsr[31:16]);
    end
    $display("test window done");
    acc(1'b1, 16'h1928, 16'h0001);
    chk(clk_pin.oe, 1'b1);
    flips = 0;
    clk_prev = clk_pin.o;
    repeat (12) begin
      cyc(1);
      if (clk_pin.o !== clk_prev) flips++;
      clk_prev = clk_pin.o;
    end
    chk(flips >= 2, 1'b1);
    acc(1'b0, 16'h1928, 16'h0000);
    ext_pull_n = 0;
    wt(1'b0, 1'b1);
    ext_pull_n = 1;
    wt(1'b0, 1'b0);
    $display("test input wake done");
    acc(1'b1, 16'h1928, 16'h0002);
    chk(clk_pin.oe, 1'b0);
    cyc(6);
    chk({wake_pin_oe, wake_wire}, 2'b01);
    alarm_in = 1;
    wt(1'b1, 1'b1);
    chk({wake_pin_o, wake_wire}, 2'b00);
    alarm_in = 0;
    wt(1'b1, 1'b0);
    chk(wake_wire, 1'b1);
    $display("test output wake done");
    alarm_in = 1;
    wt(1'b1, 1'b1);
    acc(1'b1, 16'h1928, 16'h0000);
    repeat (8) begin
      cyc(1);
      chk({wake_pin_oe, core_wake}, 2'b00);
    end
    alarm_in = 0;
    ext_pull_n = 0;
    wt(1'b0, 1'b1);
    ext_pull_n = 1;
    wt(1'b0, 1'b0);
    $display("test mode switch done");
    print_verdict;
  end
endmodule : rpw_top_tb
